// File: pmt_defines.vh
/*
 holds the register offsets, field positions and reset values of the period match timer.
 assumes it is included by its bare name from the timer design files.
*/
`ifndef PMT_DEFINES_VH
`define PMT_DEFINES_VH
`define PMT_OFF_COUNT        12'h000
`define PMT_OFF_PERIOD       12'h004
`define PMT_OFF_CONTROL      12'h008
`define PMT_OFF_FLAG         12'h00c
`define PMT_RST_COUNT        8'h00
`define PMT_RST_PERIOD       8'hff
`define PMT_RST_CONTROL      7'h00
`define PMT_CTL_PRE_LSB      0
`define PMT_CTL_PRE_MSB      1
`define PMT_CTL_RUN_BIT      2
`define PMT_CTL_POST_LSB     3
`define PMT_CTL_POST_MSB     6
`define PMT_FLAG_MATCH_BIT   1
`define PMT_INSTR_DIV        2'h3
`define PMT_PRE_DIV4_TOP     4'h3
`define PMT_PRE_DIV16_TOP    4'hf
`endif

// File: pmt_prescaler.v
/*
 prescaler: divides the instruction-rate enable by 1, 4 or 16.
 assumes clr is a one-cycle pulse and en is a one-cycle enable at instruction rate.
*/
`timescale 1ns/10ps
`include "pmt_defines.vh"
module pmt_prescaler (
   input  wire       clk,
   input  wire       rstn,
   input  wire       clr,
   input  wire       en,
   input  wire [1:0] sel,
   output wire       tick
);
   reg  [3:0] cnt_reg;
   reg  [3:0] top;

   always @* begin
      case (sel)
         2'b00:   top = 4'h0;
         2'b01:   top = `PMT_PRE_DIV4_TOP;
         default: top = `PMT_PRE_DIV16_TOP;
      endcase
   end

   assign tick = en && (cnt_reg >= top);

   always @(posedge clk) begin
      if (!rstn || clr) begin
         cnt_reg <= 4'h0;
      end else if (tick) begin
         cnt_reg <= 4'h0;
      end else if (en) begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule // pmt_prescaler

// File: pmt_timer.v
/*
 period match timer: 8-bit counter, period compare, prescaler, postscaler, apb register slave.
 assumes an apb master on clk; registers are word aligned; one clock at 20 mhz.
*/
// How it works
// - counter clocked from clk divided by four, through the prescaler
// - prescale select 00 divides 1, 01 divides 4, 1x divides 16
// - counter compared continuously with period, counts up from zero
// - on match the next increment loads zero instead of advancing
// - each match advances postscaler; its output sets the match flag
// - postscale select bits 6-3 give ratio of value plus one
// - counter and period fully readable and writable at any time
// - reset loads counter with zero and period with all ones
// - run enable bit 2 starts and stops counting
// - writing the counter clears prescaler and postscaler
// - writing control clears prescaler and postscaler, keeps counter
// - every reset clears prescaler and postscaler
// - control bit 7 reads zero; control resets to zero
`timescale 1ns/10ps
`include "pmt_defines.vh"
module pmt_timer (
   input  wire        clk,
   input  wire        rstn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         match_irq_flag
);
   reg  [7:0]  count_value_reg;
   reg  [7:0]  period_value_reg;
   reg  [6:0]  timer_control_reg;
   reg  [1:0]  instr_div_reg;
   reg  [3:0]  post_cnt_reg;
   reg  [31:0] rdata_next;
   reg         err_next;
   wire        setup;
   wire        wr;
   wire        wr_count;
   wire        wr_period;
   wire        wr_control;
   wire        wr_flag;
   wire        run;
   wire        instr_en;
   wire        pre_tick;
   wire        match;
   wire        post_fire;
   wire        scaler_clr;

   assign setup      = psel && !penable;
   assign wr         = psel && penable && pready && pwrite;
   assign wr_count   = wr && (paddr == `PMT_OFF_COUNT);
   assign wr_period  = wr && (paddr == `PMT_OFF_PERIOD);
   assign wr_control = wr && (paddr == `PMT_OFF_CONTROL);
   assign wr_flag    = wr && (paddr == `PMT_OFF_FLAG);
   assign run        = timer_control_reg[`PMT_CTL_RUN_BIT];

   assign scaler_clr = wr_count || wr_control;

   always @(posedge clk) begin
      if (!rstn) begin
         instr_div_reg <= 2'h0;
      end else begin
         instr_div_reg <= instr_div_reg + 2'h1;
      end
   end
   assign instr_en = run && (instr_div_reg == `PMT_INSTR_DIV);

   pmt_prescaler u_pre (
      .clk  (clk),
      .rstn (rstn),
      .clr  (scaler_clr),
      .en   (instr_en),
      .sel  (timer_control_reg[`PMT_CTL_PRE_MSB:`PMT_CTL_PRE_LSB]),
      .tick (pre_tick)
   );

   assign match = (count_value_reg == period_value_reg);

   assign post_fire = pre_tick && match &&
                      (post_cnt_reg == timer_control_reg[`PMT_CTL_POST_MSB:`PMT_CTL_POST_LSB]);

   always @(posedge clk) begin
      if (!rstn || scaler_clr) begin
         post_cnt_reg <= 4'h0;
      end else if (post_fire) begin
         post_cnt_reg <= 4'h0;
      end else if (pre_tick && match) begin
         post_cnt_reg <= post_cnt_reg + 4'h1;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         count_value_reg <= `PMT_RST_COUNT;
      end else if (wr_count) begin
         count_value_reg <= pwdata[7:0];
      end else if (pre_tick) begin
         if (match) begin
            count_value_reg <= 8'h00;
         end else begin
            count_value_reg <= count_value_reg + 8'h01;
         end
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         period_value_reg <= `PMT_RST_PERIOD;
      end else if (wr_period) begin
         period_value_reg <= pwdata[7:0];
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         timer_control_reg <= `PMT_RST_CONTROL;
      end else if (wr_control) begin
         timer_control_reg <= pwdata[6:0];
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         match_irq_flag <= 1'b0;
      end else if (post_fire) begin
         match_irq_flag <= 1'b1;
      end else if (wr_flag && !pwdata[`PMT_FLAG_MATCH_BIT]) begin
         match_irq_flag <= 1'b0;
      end else if (wr_flag) begin
         match_irq_flag <= 1'b1;
      end
   end

   // read mux
   always @* begin
      rdata_next = 32'h00000000;
      err_next   = 1'b0;
      case (paddr)
         `PMT_OFF_COUNT:   rdata_next = {24'h000000, count_value_reg};
         `PMT_OFF_PERIOD:  rdata_next = {24'h000000, period_value_reg};
         `PMT_OFF_CONTROL: rdata_next = {25'h0, timer_control_reg};
         `PMT_OFF_FLAG:    rdata_next = {30'h0, match_irq_flag, 1'b0};
         default:          err_next   = 1'b1;
      endcase
   end

   // apb answer one cycle after setup
   always @(posedge clk) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= err_next;
         prdata  <= pwrite ? 32'h00000000 : rdata_next;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
   end
endmodule // pmt_timer

// File: pmt_timer_props.sv
/* checker for the period match timer: apb answers and match flag.
 assumes it is bound to pmt_timer, one clock, sync active-low reset. */
`timescale 1ns/10ps
module pmt_timer_chk (
   input wire        clk,
   input wire        rstn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        match_irq_flag
);
   wire stp = psel && !penable;
   wire map = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00c;
   wire clr = psel && penable && pready && pwrite && paddr == 12'h00c && !pwdata[1];
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
   a_ready_answer: assert property (stp |=> pready) else $error("no answer after setup");
   a_ready_spurious: assert property (!stp |=> !pready) else $error("pready without setup");
   a_err_unmapped: assert property (stp && !map |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
   a_err_mapped: assert property (stp && map |=> !pslverr) else $error("mapped access refused");
   a_read_width:
      assert property (stp |=> prdata[31:8] == 24'h0) else $error("upper read bits set");
   a_ctl_bit7:
      assert property (stp && paddr == 12'h008 |=> !prdata[7]) else $error("control bit 7 set");
   a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("outputs not idle");
   a_flag_sticky:
      assert property (match_irq_flag && !clr |=> match_irq_flag) else $error("flag dropped");
   cover property (stp && !map);
   cover property ($rose(match_irq_flag));
   cover property (clr);
endmodule // pmt_timer_chk
bind pmt_timer pmt_timer_chk i_chk (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .match_irq_flag);

// File: pmt_timer_tb.sv
/* testbench for the period match timer over apb.
 assumes a 20 mhz clock; each transfer waits for pready, bounded by the watchdog. */
`timescale 1ns/10ps
module pmt_timer_tb;
   logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic        pready, pslverr, match_irq_flag;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, got;
   int          mismatches = 0, n_checks = 0, i;
   pmt_timer i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .match_irq_flag(match_irq_flag));
   initial forever #25 clk = ~clk;
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      got = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task chk(input string n, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      xfer(1'b0, 12'h000, 32'h0);
      chk("count reset", got, 32'h0);
      xfer(1'b0, 12'h004, 32'h0);
      chk("period reset", got, 32'hff);
      xfer(1'b0, 12'h008, 32'h0);
      chk("control reset", got, 32'h0);
      xfer(1'b1, 12'h008, 32'hff);
      xfer(1'b0, 12'h008, 32'h0);
      chk("control bit7", got, 32'h7f);
      xfer(1'b1, 12'h008, 32'h0);
      xfer(1'b1, 12'h000, 32'h9);
      xfer(1'b1, 12'h004, 32'h5a);
      xfer(1'b1, 12'h008, 32'h3);
      xfer(1'b0, 12'h000, 32'h0);
      chk("count kept", got, 32'h9);
      xfer(1'b0, 12'h004, 32'h0);
      chk("period rw", got, 32'h5a);
      repeat (40) @(posedge clk);
      xfer(1'b0, 12'h000, 32'h0);
      chk("count held", got, 32'h9);
      xfer(1'b0, 12'h010, 32'h0);
      chk("unmapped err", err, 1);
      xfer(1'b1, 12'h004, 32'hff);
      for (i = 0; i < 4; i++) begin
         xfer(1'b1, 12'h008, 4 + i);
         xfer(1'b1, 12'h000, 32'h0);
         repeat (256) @(posedge clk);
         xfer(1'b0, 12'h000, 32'h0);
         chk("prescale", (got + 1 - (i == 0 ? 64 : i == 1 ? 16 : 4)) <= 2, 1);
      end
      xfer(1'b1, 12'h004, 32'h0);
      for (i = 3; i < 16; i += 12) begin
         xfer(1'b1, 12'h008, (i << 3) | 4);
         xfer(1'b1, 12'h00c, 32'h0);
         xfer(1'b1, 12'h000, 32'h0);
         repeat (4 * i) @(negedge clk);
         chk("flag early", match_irq_flag, 0);
         repeat (4) @(negedge clk);
         chk("flag set", match_irq_flag, 1);
         @(posedge clk);
         xfer(1'b0, 12'h00c, 32'h0);
         chk("flag read", got, 32'h2);
      end
      xfer(1'b0, 12'h000, 32'h0);
      chk("count wraps", got, 32'h0);
      xfer(1'b1, 12'h000, 32'h33);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk("flag rerst", match_irq_flag, 0);
      xfer(1'b0, 12'h000, 32'h0);
      chk("count rerst", got, 32'h0);
      xfer(1'b0, 12'h004, 32'h0);
      chk("period rerst", got, 32'hff);
      xfer(1'b0, 12'h008, 32'h0);
      chk("control rerst", got, 32'h0);
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      report_and_stop;
   end
endmodule // pmt_timer_tb
